// [verilog/fifo_defs.vh]
`ifndef FIFO_DEFS_VH
`define FIFO_DEFS_VH
// register byte addresses
`define CTRL_ADDR 8'h00
`define AF_ADDR 8'h04
`define AE_ADDR 8'h08
`define STAT_ADDR 8'h0c
// decoded register index
`define IDX_CTRL 3'h0
`define IDX_AF 3'h1
`define IDX_AE 3'h2
`define IDX_STAT 3'h3
`define IDX_NONE 3'h4
// control fields
`define CTRL_RST 0
`define CTRL_FALL_THROUGH_MODE 1
`define CTRL_SEL_HI 3
`define CTRL_SEL_LO 2
`define CTRL_RST_VAL 4'hd
`define AF_RST_VAL 12'h004
`define AE_RST_VAL 12'h005
// answers
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
// geometry
`define MAX_DEPTH 13'h1000
`define ROWS 512
`define LANE_BITS 3'h3
`define DATA_BITS 32
`define PAR_BITS 4
`endif

// [verilog/dual_clock_bram_fifo.v]
// Summary of operation
// - shapes 4Kx4, 2Kx9, 1Kx18, 512x36 only
// - pop on read edge, push on write edge
// - push enable stores the input word
// - pop enable presents the next word
// - push while full flags overflow, stores nothing
// - pop while empty flags underflow, no advance
// - errors leave contents and pointers intact
// - almost flags have configurable thresholds
// - standard mode: first word needs a pop
// - fall-through: first word appears without pop
// - empty sets at once, clears through synchroniser
// - empty release lags first write by edges
// - capacity depth plus one, fall-through plus two
// - read pointer out, wraps to zero
// - write pointer out, wraps to zero
// - full flag marks every entry taken
// - near-full on write side, configurable offset
// - near-empty on read side, configurable offset
// - reset clears pointers, keeps memory; output cleared by sys_rst only
// - during reset empty set, full clear
// - empty clears after three or four edges
// - full sets at once, clears three edges
// - near-empty when entries at or below offset
// - near-full when free at or below offset
`timescale 1ns/1ps
`default_nettype none
`include "fifo_defs.vh"
module dual_clock_bram_fifo (
  // system
  input wire clk,
  input wire sys_rst,
  // write side
  input wire write_side_clock,
  input wire push_enable,
  input wire [31:0] write_word_in,
  input wire [3:0] write_parity_in,
  output reg full_flag,
  output reg near_full_flag,
  output reg overflow_error_flag,
  output reg [11:0] write_pointer_out,
  // read side
  input wire read_side_clock,
  input wire pop_enable,
  output reg [31:0] read_word_out,
  output reg [3:0] read_parity_out,
  output reg empty_flag,
  output reg near_empty_flag,
  output reg underflow_error_flag,
  output reg [11:0] read_pointer_out,
  // axi4-lite slave
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready
);

  function [2:0] dec;
    input [7:0] a;
    begin
      case (a)
        `CTRL_ADDR: dec = `IDX_CTRL;
        `AF_ADDR: dec = `IDX_AF;
        `AE_ADDR: dec = `IDX_AE;
        `STAT_ADDR: dec = `IDX_STAT;
        default: dec = `IDX_NONE;
      endcase
    end
  endfunction

  // row and lane of an entry inside the 36-bit wide storage
  function [8:0] row_of;
    input [1:0] sel;
    input [12:0] p;
    reg [11:0] t;
    begin
      // the wrap bit lands above the row index and is cut off here
      t = p[11:0] >> (`LANE_BITS - {1'b0, sel});
      row_of = t[8:0];
    end
  endfunction

  function [2:0] lane_of;
    input [1:0] sel;
    input [12:0] p;
    begin
      lane_of = p[2:0] & ((3'h7 >> sel));
    end
  endfunction

  // merge one entry {parity, data} into a row; 4-bit shape has no parity
  function [35:0] put;
    input [35:0] old;
    input [1:0] sel;
    input [2:0] lane;
    input [35:0] w;
    integer i;
    integer dbits;
    integer pbits;
    begin
      put = old;
      dbits = 4 << sel;
      pbits = (sel == 2'h0) ? 0 : (1 << (sel - 1));
      for (i = 0; i < `DATA_BITS; i = i + 1)
        if (i / dbits == lane)
          put[i] = w[i - lane * dbits];
      for (i = 0; i < `PAR_BITS; i = i + 1)
        if (pbits != 0 && i / pbits == lane)
          put[`DATA_BITS + i] = w[`DATA_BITS + i - lane * pbits];
    end
  endfunction

  function [35:0] get;
    input [35:0] row;
    input [1:0] sel;
    input [2:0] lane;
    integer i;
    integer dbits;
    integer pbits;
    begin
      get = 36'h0;
      dbits = 4 << sel;
      pbits = (sel == 2'h0) ? 0 : (1 << (sel - 1));
      for (i = 0; i < `DATA_BITS; i = i + 1)
        if (i < dbits)
          get[i] = row[i + lane * dbits];
      for (i = 0; i < `PAR_BITS; i = i + 1)
        if (i < pbits)
          get[`DATA_BITS + i] = row[`DATA_BITS + i + lane * pbits];
    end
  endfunction

  // configuration, held by software
  reg [3:0] ctrl_q;
  reg [11:0] af_q;
  reg [11:0] ae_q;
  wire frst = sys_rst | ctrl_q[`CTRL_RST];
  wire fall_through_mode = ctrl_q[`CTRL_FALL_THROUGH_MODE];
  wire [1:0] sel = ctrl_q[`CTRL_SEL_HI:`CTRL_SEL_LO];
  // shape only changes while the fifo is held in reset
  wire [12:0] depth = `MAX_DEPTH >> sel;
  wire [12:0] m2 = {depth[11:0], 1'b0} - 13'h1;
  wire [11:0] amask = depth[11:0] - 12'h1;

  // pin synchronisers; clocks are sampled and their edges found
  reg [37:0] ws1_q;
  reg [37:0] ws2_q;
  reg wclk3_q;
  reg [1:0] rs1_q;
  reg [1:0] rs2_q;
  reg rclk3_q;
  always @(posedge clk)
  begin
    ws1_q <= {write_side_clock, push_enable, write_parity_in, write_word_in};
    ws2_q <= ws1_q;
    wclk3_q <= ws2_q[37];
    rs1_q <= {read_side_clock, pop_enable};
    rs2_q <= rs1_q;
    rclk3_q <= rs2_q[1];
  end
  wire we = ws2_q[37] & ~wclk3_q;
  wire re = rs2_q[1] & ~rclk3_q;
  wire push_s = ws2_q[36];
  wire pop_s = rs2_q[0];

  reg [35:0] mem [0:`ROWS-1];
  reg [12:0] wp_q;
  reg [12:0] rp_q;
  reg [12:0] rp_w1_q;
  reg [12:0] rp_w2_q;
  reg [12:0] wp_s1_q;
  reg [12:0] wp_s2_q;
  reg [35:0] pf_q;
  reg pf_v_q;
  reg dout_v_q;

  // write side next state
  reg acc;
  reg [12:0] wp_d;
  reg [12:0] wcnt_d;
  always @*
  begin
    acc = push_s & ~full_flag;
    wp_d = (wp_q + {12'h0, acc}) & m2;
    wcnt_d = (wp_d - rp_w2_q) & m2;
  end

  // read side next state
  reg take;
  reg pf_use;
  reg pf_ld;
  reg pf_v_d;
  reg dout_v_d;
  reg [12:0] rp_d;
  reg [13:0] ents;
  always @*
  begin
    take = pop_s & ~empty_flag;
    pf_use = fall_through_mode ? (pf_v_q & (~dout_v_q | take)) : take;
    pf_ld = ~(pf_v_q & ~pf_use) & (((wp_s2_q - rp_q) & m2) != 13'h0);
    pf_v_d = (pf_v_q & ~pf_use) | pf_ld;
    dout_v_d = pf_use | (dout_v_q & ~take);
    rp_d = (rp_q + {12'h0, pf_ld}) & m2;
    // prefetch word and fall-through output each add one entry
    ents = {1'b0, (wp_s2_q - rp_d) & m2} + {13'h0, pf_v_d}
      + {13'h0, fall_through_mode & dout_v_d};
  end

  // storage is never cleared by reset
  always @(posedge clk)
  begin
    if (!frst && we && acc)
      mem[row_of(sel, wp_q)] <= put(mem[row_of(sel, wp_q)], sel,
        lane_of(sel, wp_q), ws2_q[35:0]);
  end

  // write side
  always @(posedge clk)
  begin
    if (frst)
    begin
      wp_q <= 13'h0;
      rp_w1_q <= 13'h0;
      rp_w2_q <= 13'h0;
      full_flag <= 1'b0;
      near_full_flag <= 1'b0;
      overflow_error_flag <= 1'b0;
      write_pointer_out <= 12'h0;
    end
    else if (we)
    begin
      wp_q <= wp_d;
      // read pointer crosses over two write edges, so full clears on third
      rp_w1_q <= rp_q;
      rp_w2_q <= rp_w1_q;
      full_flag <= (wcnt_d == depth);
      near_full_flag <= ((depth - wcnt_d) <= {1'b0, af_q});
      overflow_error_flag <= push_s & full_flag;
      write_pointer_out <= wp_d[11:0] & amask;
    end
  end

  // read side
  always @(posedge clk)
  begin
    if (frst)
    begin
      rp_q <= 13'h0;
      wp_s1_q <= 13'h0;
      wp_s2_q <= 13'h0;
      pf_v_q <= 1'b0;
      dout_v_q <= 1'b0;
      empty_flag <= 1'b1;
      near_empty_flag <= 1'b1;
      underflow_error_flag <= 1'b0;
      read_pointer_out <= 12'h0;
    end
    else if (re)
    begin
      // write pointer steps through two read-edge stages before use
      wp_s1_q <= wp_q;
      wp_s2_q <= wp_s1_q;
      rp_q <= rp_d;
      pf_v_q <= pf_v_d;
      dout_v_q <= dout_v_d;
      // set at the popping edge, cleared only via the stages above
      empty_flag <= fall_through_mode ? ~dout_v_d : ~pf_v_d;
      near_empty_flag <= (ents <= {2'h0, ae_q});
      underflow_error_flag <= pop_s & empty_flag;
      read_pointer_out <= rp_d[11:0] & amask;
    end
  end

  // prefetch word and output register survive a fifo reset
  always @(posedge clk)
  begin
    if (!frst && re && pf_ld)
      pf_q <= get(mem[row_of(sel, rp_q)], sel, lane_of(sel, rp_q));
  end
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      read_word_out <= 32'h0;
      read_parity_out <= 4'h0;
    end
    else if (!frst && re && pf_use)
    begin
      read_word_out <= pf_q[31:0];
      read_parity_out <= pf_q[35:32];
    end
  end

  // axi4-lite: address and data latched in either order, then answered
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire commit = ~awready & ~wready & ~bvalid;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_addr_q <= 8'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      ctrl_q <= `CTRL_RST_VAL;
      af_q <= `AF_RST_VAL;
      ae_q <= `AE_RST_VAL;
    end
    else
    begin
      if (awready && awvalid)
      begin
        awready <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wready && wvalid)
      begin
        wready <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (commit)
      begin
        bvalid <= 1'b1;
        bresp <= `RESP_OKAY;
        case (dec(aw_addr_q))
          `IDX_CTRL:
          begin
            if (w_strb_q[0])
              ctrl_q <= w_data_q[3:0];
          end
          `IDX_AF:
          begin
            if (w_strb_q[0])
              af_q[7:0] <= w_data_q[7:0];
            if (w_strb_q[1])
              af_q[11:8] <= w_data_q[11:8];
          end
          `IDX_AE:
          begin
            if (w_strb_q[0])
              ae_q[7:0] <= w_data_q[7:0];
            if (w_strb_q[1])
              ae_q[11:8] <= w_data_q[11:8];
          end
          `IDX_STAT: bresp <= `RESP_OKAY;
          default: bresp <= `RESP_DECERR;
        endcase
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end
    else if (arready && arvalid)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      case (dec(araddr))
        `IDX_CTRL: rdata <= {28'h0, ctrl_q};
        `IDX_AF: rdata <= {20'h0, af_q};
        `IDX_AE: rdata <= {20'h0, ae_q};
        `IDX_STAT: rdata <= {26'h0, overflow_error_flag, underflow_error_flag,
          near_full_flag, full_flag, near_empty_flag, empty_flag};
        default:
        begin
          rdata <= 32'h0;
          rresp <= `RESP_DECERR;
        end
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// [tb/fifo_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module fifo_chk (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // write side
  input wire logic full_flag,
  input wire logic near_full_flag,
  input wire logic overflow_error_flag,
  input wire logic [11:0] write_pointer_out,
  // read side
  input wire logic empty_flag,
  input wire logic near_empty_flag,
  input wire logic underflow_error_flag,
  input wire logic [11:0] read_pointer_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_ovf; $rose(overflow_error_flag) |-> $past(full_flag); endproperty
  a_ovf: assert property (p_ovf) else $error("bad overflow");
  property p_unf; $rose(underflow_error_flag) |-> $past(empty_flag);
  endproperty
  a_unf: assert property (p_unf) else $error("bad underflow");
  property p_excl; !(full_flag && empty_flag); endproperty
  a_excl: assert property (p_excl) else $error("full and empty");
  property p_nf; full_flag |-> near_full_flag; endproperty
  a_nf: assert property (p_nf) else $error("near full low");
  property p_ne; empty_flag |-> near_empty_flag; endproperty
  a_ne: assert property (p_ne) else $error("near empty low");
  // pointers only step by one or fall back to zero
  property p_wp; $changed(write_pointer_out) |-> write_pointer_out == 12'h0
    || write_pointer_out == $past(write_pointer_out) + 12'h1; endproperty
  a_wp: assert property (p_wp) else $error("write pointer jump");
  property p_rp; $changed(read_pointer_out) |-> read_pointer_out == 12'h0
    || read_pointer_out == $past(read_pointer_out) + 12'h1; endproperty
  a_rp: assert property (p_rp) else $error("read pointer jump");
  property p_rst; $fell(sys_rst) |-> empty_flag && near_empty_flag
    && !full_flag && !near_full_flag; endproperty
  a_rst: assert property (p_rst) else $error("reset flags");
  cover property ($rose(full_flag));
  cover property ($rose(overflow_error_flag));
  cover property ($fell(empty_flag));
endmodule
bind dual_clock_bram_fifo fifo_chk i_fifo_chk (.*);
`default_nettype wire

// [tb/fifo_user_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fifo_user_model (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // bench control
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic force_err,
  // flags
  input wire logic full_flag,
  input wire logic empty_flag,
  input wire logic overflow_error_flag,
  input wire logic underflow_error_flag,
  // link side
  output logic write_side_clock,
  output logic read_side_clock,
  output logic push_enable,
  output logic pop_enable,
  output logic [31:0] write_word_in,
  output logic [3:0] write_parity_in,
  output logic got
);
  logic wq, rq;
  logic [2:0] wf, rf;
  logic [7:0] seq;
  // free-running clocks; read offset so phases never line up
  initial
  begin
    write_side_clock = 0;
    forever #80 write_side_clock = ~write_side_clock;
  end
  initial
  begin
    read_side_clock = 0;
    #37;
    forever #80 read_side_clock = ~read_side_clock;
  end
  // idle lines show the inverse, never a stale word
  assign write_word_in = push_enable ? {4{seq}} : ~{4{seq}};
  assign write_parity_in = push_enable ? seq[3:0] : ~seq[3:0];
  // act three clk after a link fall is seen, clear of the next rise
  always @(posedge clk)
  begin
    wq <= write_side_clock;
    rq <= read_side_clock;
    wf <= {wf[1:0], wq & ~write_side_clock};
    rf <= {rf[1:0], rq & ~read_side_clock};
    got <= rf[2] & pop_enable & ~underflow_error_flag;
    if (sys_rst)
    begin
      push_enable <= 1'b0;
      pop_enable <= 1'b0;
      seq <= 8'h0;
    end
    else
    begin
      if (wf[2])
      begin
        seq <= seq + {7'h0, push_enable & ~overflow_error_flag};
        push_enable <= push_req & (~full_flag | force_err);
      end
      if (rf[2])
        pop_enable <= pop_req & (~empty_flag | force_err);
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, sys_rst = 1, push_req = 0, pop_req = 0, force_err = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire write_side_clock, read_side_clock, push_enable, pop_enable, got;
  wire [31:0] write_word_in, read_word_out, rdata;
  wire [3:0] write_parity_in, read_parity_out;
  wire full_flag, near_full_flag, overflow_error_flag, empty_flag;
  wire near_empty_flag, underflow_error_flag, awready, wready, bvalid;
  wire arready, rvalid;
  wire [11:0] write_pointer_out, read_pointer_out;
  wire [1:0] bresp, rresp;
  int failures = 0, comparisons = 0, cycles = 0, nr = 0, n = 0;
  logic [35:0] msk = 36'hf_ffff_ffff;
  dual_clock_bram_fifo i_dual_clock_bram_fifo (.*);
  fifo_user_model i_fifo_user_model (.*);
  always #10 clk = ~clk;
  task summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [35:0] g, input [35:0] e);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic [35:0] pat(input int k);
    pat = {k[3:0], {4{k[7:0]}}};
  endfunction
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (got === 1'b1)
    begin
      chk({read_parity_out, read_word_out}, pat(nr) & msk);
      nr++;
    end
    if (cycles == 20000)
    begin
      failures++;
      summarize;
    end
  end
  task axw(input [7:0] a, input [31:0] d, input [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid & bready)
      begin
        bready <= 1'b0;
        chk(bresp, {34'h0, r});
      end
    end
    while (awvalid | wvalid | bready);
  endtask
  task axr(input [7:0] a, input [31:0] d, input [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid & rready)
      begin
        rready <= 1'b0;
        chk({rresp, rdata}, {r, d});
      end
    end
    while (arvalid | rready);
  endtask
  // enables stay low while the fifo is held in reset
  task go(input [31:0] c);
    axw(8'h00, c | 32'h1, 2'h0);
    tick(40);
    axw(8'h00, c, 2'h0);
    tick(8);
  endtask
  task push_one;
    push_req <= 1'b1;
    while (push_enable !== 1'b1)
      @(posedge clk);
    push_req <= 1'b0;
    tick(80);
  endtask
  task t_regs;
    axr(8'h00, 32'hd, 2'h0);
    axw(8'h08, 32'h7, 2'h0);
    axr(8'h08, 32'h7, 2'h0);
    axw(8'h0c, 32'hff, 2'h0);
    axr(8'h0c, 32'h3, 2'h0);
    axw(8'h10, 32'h1, 2'h3);
    axr(8'h10, 32'h0, 2'h3);
    $display("register test done");
  endtask
  task t_std;
    go(32'hc);
    push_one;
    chk({read_parity_out, read_word_out}, 36'h0);
    axr(8'h0c, 32'h2, 2'h0);
    pop_req <= 1'b1;
    while (nr < 1)
      @(posedge clk);
    force_err <= 1'b1;
    tick(40);
    chk(underflow_error_flag, 36'h1);
    chk(read_pointer_out, 36'h1);
    pop_req <= 1'b0;
    force_err <= 1'b0;
    $display("standard test done");
  endtask
  task t_full;
    axw(8'h04, 32'h100, 2'h0);
    push_req <= 1'b1;
    while (near_full_flag !== 1'b1)
      @(posedge clk);
    chk(write_pointer_out, 36'h102);
    chk(full_flag, 36'h0);
    while (full_flag !== 1'b1)
      @(posedge clk);
    chk(near_full_flag, 36'h1);
    axr(8'h0c, 32'hc, 2'h0);
    force_err <= 1'b1;
    tick(40);
    chk(overflow_error_flag, 36'h1);
    chk(write_pointer_out, 36'h2);
    force_err <= 1'b0;
    push_req <= 1'b0;
    n = nr;
    pop_req <= 1'b1;
    while (nr < n + 513)
      @(posedge clk);
    tick(80);
    chk(nr - n, 513);
    chk(empty_flag, 36'h1);
    pop_req <= 1'b0;
    $display("full test done");
  endtask
  task t_narrow;
    go(32'h0);
    msk = 36'hf;
    n = nr;
    push_one;
    push_one;
    pop_req <= 1'b1;
    while (nr < n + 2)
      @(posedge clk);
    pop_req <= 1'b0;
    tick(40);
    chk(nr - n, 2);
    chk(read_pointer_out, 36'h2);
    chk(write_pointer_out, 36'h2);
    $display("narrow test done");
  endtask
  task t_fall_through_mode;
    go(32'he);
    chk({read_parity_out, read_word_out}, pat(nr - 1) & msk);
    msk = 36'hf_ffff_ffff;
    push_one;
    chk({read_parity_out, read_word_out}, pat(nr));
    chk(empty_flag, 36'h0);
    $display("fall-through test done");
  endtask
  initial
  begin
    tick(8);
    sys_rst <= 1'b0;
    tick(1);
    t_regs;
    t_std;
    t_full;
    t_narrow;
    t_fall_through_mode;
    summarize;
  end
endmodule
`default_nettype wire
